// *** src/sfepc_ctrl.v ***
// Erase, program, power-down and OTP command logic of a serial flash
//
// Behaviour
// - Opcode: eight clocks single, two clocks quad
// - Deselect starts timed cycle; end clears busy, latch
// - Protected blocks or pages are never modified
// - 64K erase needs latch, any block address
// - Erase deselect off byte boundary is rejected
// - Chip erase only with all protect bits zero
// - Page program clears bits, needs latch first
// - Beyond 256 bytes, only last 256 kept
// - Overrun wraps to start of same page
// - Unsent bytes of the page stay unchanged
// - Program needs data byte, deselect on boundary
// - Quad program needs quad enable, four lines
// - Quad program accepted only in single-line form
// - Power-down ignores all but release and reset
// - Power-down on boundary, entered after delay
// - Software reset ends power-down; reset gives standby
// - OTP entry steers program to OTP region
// - OTP mode refuses status and security writes
// - OTP exit returns to main array
// - Locked OTP refuses update; no array access
`timescale 1ns/10ps
`include "sfepc_defines.vh"
module sfepc_ctrl #(
  parameter [31:0] ERASE32_CYC = `SFEPC_ERASE_32K_TIME_US * `SFEPC_CLK_MHZ,
  parameter [31:0] ERASE64_CYC = `SFEPC_ERASE_64K_TIME_US * `SFEPC_CLK_MHZ,
  parameter [31:0] CHIP_CYC = `SFEPC_CHIP_ERASE_TIME_US * `SFEPC_CLK_MHZ,
  parameter [31:0] PROG_CYC = `SFEPC_PAGE_PROGRAM_TIME_US * `SFEPC_CLK_MHZ
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire ARST_N,
  // Serial pins
  input wire CS_N,
  input wire SCLK,
  input wire [3:0] QUAD_IO_LINES,
  // Configuration
  input wire QPI_MODE,
  input wire QUAD_LINES_ENABLE,
  input wire BLOCK_PROTECT_0,
  input wire BLOCK_PROTECT_1,
  input wire BLOCK_PROTECT_2,
  input wire BLOCK_PROTECT_3,
  input wire OTP_LOCKDOWN_BIT,
  // Status
  output reg WRITE_IN_PROGRESS,
  output reg WRITE_ENABLE_LATCH,
  output reg DEEP_POWER_DOWN,
  output reg OTP_MODE,
  output reg REG_WRITE_ALLOW,
  output reg CMD_REJECT,
  // Array operation stream
  output wire OP_VALID,
  input wire OP_READY,
  output wire [2:0] OP_KIND,
  output wire OP_OTP,
  output wire [23:0] OP_ADDR,
  output wire [7:0] OP_DATA
);
  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_EMIT = 3'h2;
  localparam [2:0] ST_WAIT = 3'h4;
  localparam [9:0] DP_CYC = `SFEPC_POWER_DOWN_ENTRY_DELAY_US * `SFEPC_CLK_MHZ;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Protect level n covers the top 2^(n-1) 64K blocks, 9 and up all
  function is_prot;
    input [23:0] a;
    input [3:0] bp;
    reg [8:0] first;
    begin
      first = 9'h100 - (9'h001 << (bp - 4'h1));
      if (bp == 4'h0) begin
        is_prot = 1'b0;
      end else if (bp > 4'h8) begin
        is_prot = 1'b1;
      end else begin
        is_prot = ({1'b0, a[23:16]} >= first);
      end
    end
  endfunction

  function [31:0] cycle_time;
    input [2:0] kind;
    begin
      case (kind)
        `SFEPC_KIND_ERASE_32K: cycle_time = ERASE32_CYC;
        `SFEPC_KIND_ERASE_64K: cycle_time = ERASE64_CYC;
        `SFEPC_KIND_CHIP_ERASE: cycle_time = CHIP_CYC;
        default: cycle_time = PROG_CYC;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  wire [5:0] pins_s;
  reg cs_d;
  reg sclk_d;

  sfepc_sync #(
    .W(6)
  ) u_sync (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .d({CS_N, SCLK, QUAD_IO_LINES}),
    .q(pins_s)
  );

  wire cs_s = pins_s[5];
  wire sclk_s = pins_s[4];
  wire [3:0] sio_s = pins_s[3:0];
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  wire cs_fall = ~cs_s & cs_d;
  wire cs_rise = cs_s & ~cs_d;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  reg [7:0] shift;
  reg [2:0] bitpos;
  reg [2:0] nbytes;
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [7:0] col;
  reg [7:0] page_mem [0:`SFEPC_PAGE_BYTES-1];
  reg [`SFEPC_PAGE_BYTES-1:0] page_mask;

  // Address and data go quad in quad form or for the quad program
  wire quad = QPI_MODE |
    ((nbytes != 3'h0) & (opcode == `SFEPC_OPC_QUAD_PAGE_PROGRAM));
  // Upper lines are don't care in single-line form
  wire [7:0] next_shift = quad ? {shift[3:0], sio_s} : {shift[6:0], sio_s[0]};
  wire [2:0] next_bitpos = bitpos + (quad ? 3'h4 : 3'h1);
  wire byte_done = sclk_rise & (next_bitpos == 3'h0);
  wire op_prog = (opcode == `SFEPC_OPC_PAGE_PROGRAM) |
    (opcode == `SFEPC_OPC_QUAD_PAGE_PROGRAM);
  wire take_data = byte_done & (nbytes >= 3'h4) & op_prog & ~WRITE_IN_PROGRESS;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      shift <= 8'h00;
      bitpos <= 3'h0;
      nbytes <= 3'h0;
      opcode <= 8'h00;
      addr <= 24'h000000;
      col <= 8'h00;
      page_mask <= {`SFEPC_PAGE_BYTES{1'b0}};
    end else begin
      if (cs_fall) begin
        bitpos <= 3'h0;
        nbytes <= 3'h0;
        opcode <= 8'h00;
        // The mask is still being drained while busy
        if (!WRITE_IN_PROGRESS) begin
          page_mask <= {`SFEPC_PAGE_BYTES{1'b0}};
        end
      end else if (sclk_rise) begin
        shift <= next_shift;
        bitpos <= next_bitpos;
        if (byte_done) begin
          if (nbytes != 3'h7) begin
            nbytes <= nbytes + 3'h1;
          end
          if (nbytes == 3'h0) begin
            opcode <= next_shift;
          end
          if (nbytes >= 3'h1 && nbytes <= 3'h3 && !WRITE_IN_PROGRESS) begin
            addr <= {addr[15:0], next_shift};
          end
          if (nbytes == 3'h3) begin
            col <= next_shift;
          end
          if (take_data) begin
            page_mask[col] <= 1'b1;
            col <= col + 8'h01;
          end
        end
      end
    end
  end

  // Later bytes overwrite earlier ones at the same column
  always @(posedge CLK_SYS) begin
    if (take_data) begin
      page_mem[col] <= next_shift;
    end
  end

  // ----------------------------------------------------------------
  // Command decision at deselect
  // ----------------------------------------------------------------
  wire [3:0] bp = {BLOCK_PROTECT_3, BLOCK_PROTECT_2, BLOCK_PROTECT_1, BLOCK_PROTECT_0};
  wire boundary = (bitpos == 3'h0);
  wire opcode_only = boundary & (nbytes == 3'h1);
  wire can_write = WRITE_ENABLE_LATCH & ~WRITE_IN_PROGRESS & ~DEEP_POWER_DOWN;
  wire op_e32 = (opcode == `SFEPC_OPC_ERASE_32K);
  wire op_e64 = (opcode == `SFEPC_OPC_ERASE_64K);
  wire op_ce = (opcode == `SFEPC_OPC_CHIP_ERASE) | (opcode == `SFEPC_OPC_CHIP_ERASE_ALT);
  wire op_dp = (opcode == `SFEPC_OPC_DEEP_POWER_DOWN);
  wire quad_ok = ~QPI_MODE & QUAD_LINES_ENABLE;
  wire prog_form = (opcode == `SFEPC_OPC_PAGE_PROGRAM) |
    ((opcode == `SFEPC_OPC_QUAD_PAGE_PROGRAM) & quad_ok);

  // Erase needs exactly opcode and three address bytes
  wire erase_ok = (op_e32 | op_e64) & boundary & (nbytes == 3'h4) &
    can_write & ~OTP_MODE & ~is_prot(addr, bp);
  wire chip_ok = op_ce & opcode_only & can_write &
    ~OTP_MODE & (bp == 4'h0);
  // In OTP mode a program lands in the OTP region unless locked
  wire prog_ok = prog_form & boundary & (nbytes >= 3'h5) & can_write &
    (OTP_MODE ? ~OTP_LOCKDOWN_BIT : ~is_prot(addr, bp));
  wire dp_ok = op_dp & opcode_only & ~DEEP_POWER_DOWN;
  wire release_ok = (opcode == `SFEPC_OPC_RELEASE_PD) & (nbytes != 3'h0);
  wire awake = ~DEEP_POWER_DOWN;
  wire write_enable_cmd_ok = (opcode == `SFEPC_OPC_WRITE_ENABLE) & opcode_only & awake &
    ~WRITE_IN_PROGRESS;
  wire enter_ok = (opcode == `SFEPC_OPC_OTP_ENTER) & opcode_only & awake;
  wire exit_ok = (opcode == `SFEPC_OPC_OTP_EXIT) & opcode_only & awake;
  wire rsten_ok = (opcode == `SFEPC_OPC_RESET_ENABLE) & opcode_only;
  wire rst_ok = (opcode == `SFEPC_OPC_RESET) & opcode_only;
  wire write_class = op_e32 | op_e64 | op_ce | op_dp | op_prog;
  wire accept = erase_ok | chip_ok | prog_ok;

  // ----------------------------------------------------------------
  // Mode flags
  // ----------------------------------------------------------------
  reg reset_armed;
  reg dp_pending;
  reg [9:0] dp_count;
  reg [2:0] state;
  reg [2:0] next_state;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      // Power-up lands in standby, never in power-down
      DEEP_POWER_DOWN <= 1'b0;
      OTP_MODE <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
      REG_WRITE_ALLOW <= 1'b0;
      CMD_REJECT <= 1'b0;
      reset_armed <= 1'b0;
      dp_pending <= 1'b0;
      dp_count <= 10'h000;
    end else begin
      CMD_REJECT <= cs_rise & (nbytes != 3'h0) & write_class & ~accept & ~dp_ok;
      REG_WRITE_ALLOW <= ~OTP_MODE & ~DEEP_POWER_DOWN & ~WRITE_IN_PROGRESS;
      if (dp_pending) begin
        if (dp_count == 10'h001) begin
          DEEP_POWER_DOWN <= 1'b1;
          dp_pending <= 1'b0;
        end
        dp_count <= dp_count - 10'h001;
      end
      if (state == ST_WAIT && next_state == ST_IDLE) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end
      if (cs_rise) begin
        reset_armed <= rsten_ok;
        if (rst_ok && reset_armed) begin
          // Reset ends power-down and any OTP session
          DEEP_POWER_DOWN <= 1'b0;
          dp_pending <= 1'b0;
          OTP_MODE <= 1'b0;
          if (!WRITE_IN_PROGRESS) begin
            WRITE_ENABLE_LATCH <= 1'b0;
          end
        end else if (DEEP_POWER_DOWN) begin
          if (release_ok) begin
            DEEP_POWER_DOWN <= 1'b0;
          end
        end else begin
          if (release_ok) begin
            dp_pending <= 1'b0;
          end
          if (dp_ok) begin
            dp_pending <= 1'b1;
            dp_count <= DP_CYC;
          end
          if (write_enable_cmd_ok) begin
            WRITE_ENABLE_LATCH <= 1'b1;
          end
          if (enter_ok) begin
            OTP_MODE <= 1'b1;
            REG_WRITE_ALLOW <= 1'b0;
          end
          if (exit_ok) begin
            OTP_MODE <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed cycle
  // ----------------------------------------------------------------
  reg [2:0] kind;
  reg single;
  reg op_otp;
  reg [7:0] idx;
  reg [31:0] timer;
  wire buf_ready;
  wire buf_valid = (state == ST_EMIT) & (single | page_mask[idx]);
  wire step = (buf_valid & buf_ready) | ((state == ST_EMIT) & ~single & ~page_mask[idx]);
  wire last = single | (idx == 8'hFF);
  wire [23:0] word_addr = single ? addr : {addr[23:8], idx};
  wire [7:0] word_data = single ? 8'hFF : page_mem[idx];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_rise && accept) begin
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (step && last) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timer == 32'h00000000) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      WRITE_IN_PROGRESS <= 1'b0;
      kind <= `SFEPC_KIND_PROGRAM;
      single <= 1'b0;
      op_otp <= 1'b0;
      idx <= 8'h00;
      timer <= 32'h00000000;
    end else begin
      state <= next_state;
      WRITE_IN_PROGRESS <= (next_state != ST_IDLE);
      case (state)
        ST_IDLE: begin
          if (cs_rise && accept) begin
            single <= ~prog_ok;
            op_otp <= OTP_MODE;
            idx <= 8'h00;
            if (op_e32) begin
              kind <= `SFEPC_KIND_ERASE_32K;
            end else if (op_e64) begin
              kind <= `SFEPC_KIND_ERASE_64K;
            end else if (op_ce) begin
              kind <= `SFEPC_KIND_CHIP_ERASE;
            end else begin
              kind <= `SFEPC_KIND_PROGRAM;
            end
          end
        end
        ST_EMIT: begin
          if (step) begin
            idx <= idx + 8'h01;
            if (last) begin
              timer <= cycle_time(kind) - 32'h00000001;
            end
          end
        end
        ST_WAIT: begin
          if (timer != 32'h00000000) begin
            timer <= timer - 32'h00000001;
          end
        end
        default: idx <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operation buffer toward the array
  // ----------------------------------------------------------------
  // A stalled array holds the cycle in emission, so nothing is lost
  wire [`SFEPC_WORD_W-1:0] buf_out;

  sfepc_buf2 #(
    .W(`SFEPC_WORD_W)
  ) u_buf (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .in_valid(buf_valid),
    .in_ready(buf_ready),
    .in_data({kind, op_otp, word_addr, word_data}),
    .out_valid(OP_VALID),
    .out_ready(OP_READY),
    .out_data(buf_out)
  );

  assign OP_KIND = buf_out[35:33];
  assign OP_OTP = buf_out[32];
  assign OP_ADDR = buf_out[31:8];
  assign OP_DATA = buf_out[7:0];
endmodule

// *** src/sfepc_defines.vh ***
// Constants of the serial flash erase and program controller
`ifndef SFEPC_DEFINES_VH
`define SFEPC_DEFINES_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SFEPC_OPC_WRITE_ENABLE 8'h06
`define SFEPC_OPC_ERASE_32K 8'h52
`define SFEPC_OPC_ERASE_64K 8'hD8
`define SFEPC_OPC_CHIP_ERASE 8'h60
`define SFEPC_OPC_CHIP_ERASE_ALT 8'hC7
`define SFEPC_OPC_PAGE_PROGRAM 8'h02
`define SFEPC_OPC_QUAD_PAGE_PROGRAM 8'h38
`define SFEPC_OPC_DEEP_POWER_DOWN 8'hB9
`define SFEPC_OPC_RELEASE_PD 8'hAB
`define SFEPC_OPC_OTP_ENTER 8'hB1
`define SFEPC_OPC_OTP_EXIT 8'hC1
`define SFEPC_OPC_RESET_ENABLE 8'h66
`define SFEPC_OPC_RESET 8'h99

// ----------------------------------------------------------------
// Array operation word: kind, otp flag, address, data
// ----------------------------------------------------------------
`define SFEPC_KIND_ERASE_32K 3'h1
`define SFEPC_KIND_ERASE_64K 3'h2
`define SFEPC_KIND_CHIP_ERASE 3'h3
`define SFEPC_KIND_PROGRAM 3'h4
`define SFEPC_WORD_W 36
`define SFEPC_PAGE_BYTES 256

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFEPC_CLK_MHZ 40
`define SFEPC_ERASE_32K_TIME_US 150000
`define SFEPC_ERASE_64K_TIME_US 300000
`define SFEPC_CHIP_ERASE_TIME_US 40000000
`define SFEPC_PAGE_PROGRAM_TIME_US 1000
`define SFEPC_POWER_DOWN_ENTRY_DELAY_US 10

`endif

// *** src/sfepc_sync.v ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module sfepc_sync #(
  parameter W = 6
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** src/sfepc_buf2.v ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sfepc_buf2 #(
  parameter W = 36
) (
  input wire clk,
  input wire arst_n,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg spare_valid;
  reg [W-1:0] spare_data;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Head and spare are both flops so the outputs never pass a mux
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
      spare_valid <= 1'b0;
      spare_data <= {W{1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (!out_valid || pop) begin
        if (spare_valid) begin
          out_data <= spare_data;
          out_valid <= 1'b1;
          spare_valid <= push;
          if (push) begin
            spare_data <= in_data;
          end
          in_ready <= ~push;
        end else begin
          out_valid <= push;
          if (push) begin
            out_data <= in_data;
          end
          in_ready <= 1'b1;
        end
      end else if (push) begin
        spare_data <= in_data;
        spare_valid <= 1'b1;
        in_ready <= 1'b0;
      end
    end
  end
endmodule

// *** tb/sfepc_ctrl_checker.sv ***
// Port-level assertions of the erase and program controller
`timescale 1ns/10ps
`include "sfepc_defines.vh"
module sfepc_ctrl_checker (
  // Clock and reset
  input wire CLK_SYS,
  input wire ARST_N,
  // Pins and configuration
  input wire CS_N,
  input wire OP_READY,
  input wire BLOCK_PROTECT_0,
  input wire BLOCK_PROTECT_1,
  input wire BLOCK_PROTECT_2,
  input wire BLOCK_PROTECT_3,
  input wire OTP_LOCKDOWN_BIT,
  // Status and stream
  input wire WRITE_IN_PROGRESS,
  input wire WRITE_ENABLE_LATCH,
  input wire DEEP_POWER_DOWN,
  input wire OTP_MODE,
  input wire REG_WRITE_ALLOW,
  input wire CMD_REJECT,
  input wire OP_VALID,
  input wire [2:0] OP_KIND,
  input wire OP_OTP,
  input wire [23:0] OP_ADDR,
  input wire [7:0] OP_DATA
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  // ----------------------------------------
  // Steps
  // ----------------------------------------
  sequence busy_start;
    !WRITE_IN_PROGRESS ##1 WRITE_IN_PROGRESS;
  endsequence
  sequence busy_end;
    WRITE_IN_PROGRESS ##1 !WRITE_IN_PROGRESS;
  endsequence
  sequence pd_entry;
    !DEEP_POWER_DOWN ##1 DEEP_POWER_DOWN;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_end_clears_wel: assert property (busy_end |-> !WRITE_ENABLE_LATCH)
    else $error("latch set after cycle end");
  a_start_deselected: assert property (busy_start |-> CS_N && !DEEP_POWER_DOWN)
    else $error("cycle started while selected or asleep");
  a_words_in_cycle: assert property (OP_VALID |-> WRITE_IN_PROGRESS)
    else $error("array word outside cycle");
  a_stall_holds: assert property (OP_VALID && !OP_READY |=> OP_VALID && $stable(OP_ADDR)
    && $stable(OP_DATA) && $stable(OP_KIND) && $stable(OP_OTP))
    else $error("word changed while stalled");
  a_erase_ones: assert property (OP_VALID && OP_KIND != `SFEPC_KIND_PROGRAM |-> OP_DATA == 8'hFF)
    else $error("erase word not all ones");
  a_chip_unprotected: assert property (OP_VALID && OP_KIND == `SFEPC_KIND_CHIP_ERASE |->
    {BLOCK_PROTECT_3, BLOCK_PROTECT_2, BLOCK_PROTECT_1, BLOCK_PROTECT_0} == 4'h0)
    else $error("chip erase under protection");
  a_otp_no_regwr: assert property (OTP_MODE |-> !REG_WRITE_ALLOW)
    else $error("register write allowed in otp mode");
  a_otp_steer: assert property (OP_VALID |-> OP_OTP == OTP_MODE)
    else $error("word region differs from mode");
  a_otp_locked: assert property (OP_VALID && OP_OTP |-> !OTP_LOCKDOWN_BIT
    && OP_KIND == `SFEPC_KIND_PROGRAM) else $error("locked or erased otp region");
  a_reject_pulse: assert property (CMD_REJECT |=> !CMD_REJECT)
    else $error("reject longer than one cycle");
  a_pd_after_edge: assert property (pd_entry |-> CS_N && $past(CS_N, 8))
    else $error("power-down without prior deselect");
endmodule
bind sfepc_ctrl sfepc_ctrl_checker u_sfepc_ctrl_checker (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CS_N(CS_N), .OP_READY(OP_READY),
  .BLOCK_PROTECT_0(BLOCK_PROTECT_0), .BLOCK_PROTECT_1(BLOCK_PROTECT_1),
  .BLOCK_PROTECT_2(BLOCK_PROTECT_2), .BLOCK_PROTECT_3(BLOCK_PROTECT_3),
  .OTP_LOCKDOWN_BIT(OTP_LOCKDOWN_BIT), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .DEEP_POWER_DOWN(DEEP_POWER_DOWN),
  .OTP_MODE(OTP_MODE), .REG_WRITE_ALLOW(REG_WRITE_ALLOW), .CMD_REJECT(CMD_REJECT),
  .OP_VALID(OP_VALID), .OP_KIND(OP_KIND), .OP_OTP(OP_OTP), .OP_ADDR(OP_ADDR),
  .OP_DATA(OP_DATA)
);

// *** tb/sfepc_host.sv ***
// Host controller model driving the serial pins
`timescale 1ns/10ps
module sfepc_host (
  // Clock
  input wire clk,
  // Serial pins
  output reg cs_n,
  output reg sclk,
  output reg [3:0] io
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io = 4'h0;
  end
  // Half a link period: four system clocks
  task automatic half;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic start;
    half;
    cs_n = 1'b0;
    half;
  endtask
  // n clocks taken from the top of b, a bit or a nibble per clock
  task automatic bits(input [7:0] b, input integer n, input quad);
    integer i;
    reg [7:0] s;
    s = b;
    for (i = 0; i < n; i = i + 1) begin
      if (quad) begin
        io = s[7:4];
        s = {s[3:0], 4'h0};
      end else begin
        // Upper lines toggle so that they cannot help the design
        io = {~io[3:1], s[7]};
        s = {s[6:0], 1'b0};
      end
      half;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
    end
  endtask
  // Clock stays low outside frames; released lines show the inverse
  task automatic stop;
    half;
    cs_n = 1'b1;
    io = ~io;
    half;
    half;
  endtask
endmodule

// *** tb/sfepc_ctrl_test.sv ***
// Self-checking bench of the erase and program controller
`timescale 1ns/10ps
`include "sfepc_defines.vh"
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
  fail_count = fail_count + 1; $display("unexpected at %0t: %0h vs %0h", $time, (a), (b)); end end
module sfepc_ctrl_test;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg qpi = 1'b0;
  reg qe = 1'b0;
  reg [3:0] bp = 4'h0;
  reg lock = 1'b0;
  reg op_ready = 1'b0;
  wire cs_n;
  wire sclk;
  wire [3:0] io;
  wire write_in_progress;
  wire write_enable_latch;
  wire dpd;
  wire otp;
  wire regwr;
  wire rej;
  wire op_valid;
  wire [2:0] op_kind;
  wire op_otp;
  wire [23:0] op_addr;
  wire [7:0] op_data;
  integer fail_count = 0;
  integer check_count = 0;
  integer rej_cnt = 0;
  integer rej0 = 0;
  integer cycles = 0;
  integer i;
  reg [35:0] words[$];
  reg [35:0] w;
  sfepc_host u_sfepc_host (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk), .io(io));
  sfepc_ctrl #(.ERASE32_CYC(32'hBB8), .ERASE64_CYC(32'hBB8), .CHIP_CYC(32'h14),
    .PROG_CYC(32'h14)) u_sfepc_ctrl (.CLK_SYS(clk_sys), .ARST_N(arst_n), .CS_N(cs_n),
    .SCLK(sclk), .QUAD_IO_LINES(io), .QPI_MODE(qpi), .QUAD_LINES_ENABLE(qe),
    .BLOCK_PROTECT_0(bp[0]), .BLOCK_PROTECT_1(bp[1]), .BLOCK_PROTECT_2(bp[2]),
    .BLOCK_PROTECT_3(bp[3]), .OTP_LOCKDOWN_BIT(lock), .WRITE_IN_PROGRESS(write_in_progress),
    .WRITE_ENABLE_LATCH(write_enable_latch), .DEEP_POWER_DOWN(dpd), .OTP_MODE(otp),
    .REG_WRITE_ALLOW(regwr), .CMD_REJECT(rej), .OP_VALID(op_valid), .OP_READY(op_ready),
    .OP_KIND(op_kind), .OP_OTP(op_otp), .OP_ADDR(op_addr), .OP_DATA(op_data));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Array side: long stalls fill the buffer
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    op_ready <= #1 (cycles[2:0] > 3'h5);
    if (op_valid && op_ready) words.push_back({op_kind, op_otp, op_addr, op_data});
    if (rej) rej_cnt <= rej_cnt + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function [7:0] dat(input integer n);
    dat = n[7:0] ^ {n[8], 7'h00} ^ 8'h3C;
  endfunction
  task automatic frame(input [7:0] op, input [23:0] a, input integer nab, input integer nd,
    input integer extra, input qo, input qr);
    integer k;
    rej0 = rej_cnt;
    u_sfepc_host.start;
    u_sfepc_host.bits(op, qo ? 2 : 8, qo);
    for (k = 0; k < nab; k = k + 1) u_sfepc_host.bits(a[23 - 8 * k -: 8], qr ? 2 : 8, qr);
    for (k = 0; k < nd; k = k + 1) u_sfepc_host.bits(dat(k), qr ? 2 : 8, qr);
    if (extra > 0) u_sfepc_host.bits(8'hA5, extra, 1'b0);
    u_sfepc_host.stop;
  endtask
  task automatic sc(input [7:0] op);
    frame(op, 24'h000000, 0, 0, 0, qpi, qpi);
  endtask
  task automatic done(input acc);
    integer n;
    `CHK(rej_cnt - rej0, acc ? 0 : 1)
    n = 0;
    while (write_in_progress === 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    `CHK({write_in_progress, write_enable_latch & acc}, 2'h0)
  endtask
  task automatic word(input [2:0] k, input o, input [23:0] a, input [7:0] d);
    w = words.size() > 0 ? words.pop_front() : 36'h0;
    `CHK(w, {k, o, a, d})
  endtask
  task automatic rst;
    #1 arst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK({write_in_progress, write_enable_latch, dpd, otp, op_valid}, 5'h00)
  endtask
  task automatic t_erase;
    for (i = 0; i < 2; i = i + 1) begin
      qpi = i;
      frame(8'hD8, 24'h123456, 3, 0, 0, qpi, qpi);
      done(1'b0);
      sc(8'h06);
      frame(i ? 8'h52 : 8'hD8, 24'h123456, 3, 0, 0, qpi, qpi);
      `CHK(write_in_progress, 1'b1)
      frame(8'hD8, 24'h200000, 3, 0, 0, qpi, qpi);
      done(1'b0);
      `CHK(write_enable_latch, 1'b0)
      word(i ? `SFEPC_KIND_ERASE_32K : `SFEPC_KIND_ERASE_64K, 1'b0, 24'h123456, 8'hFF);
    end
    qpi = 1'b0;
  endtask
  task automatic t_boundary;
    sc(8'h06);
    frame(8'hD8, 24'h010000, 3, 0, 4, 0, 0);
    done(1'b0);
    sc(8'h06);
    frame(8'hD8, 24'h010000, 2, 0, 0, 0, 0);
    done(1'b0);
    sc(8'h06);
    frame(8'h02, 24'h000100, 3, 0, 0, 0, 0);
    done(1'b0);
    sc(8'h06);
    frame(8'h02, 24'h000100, 3, 1, 3, 0, 0);
    done(1'b0);
    `CHK(words.size(), 0)
  endtask
  task automatic t_chip;
    bp = 4'h2;
    sc(8'h06);
    sc(8'h60);
    done(1'b0);
    bp = 4'h0;
    sc(8'h06);
    frame(8'h60, 24'h000000, 1, 0, 0, 0, 0);
    done(1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      sc(8'h06);
      sc(i ? 8'hC7 : 8'h60);
      done(1'b1);
      w = words.size() > 0 ? words.pop_front() : 36'h0;
      `CHK({w[35:32], w[7:0]}, {`SFEPC_KIND_CHIP_ERASE, 1'b0, 8'hFF})
    end
  endtask
  task automatic t_otp;
    sc(8'hB1);
    `CHK({otp, regwr}, 2'h2)
    sc(8'h06);
    frame(8'h02, 24'h000010, 3, 1, 0, 0, 0);
    done(1'b1);
    word(`SFEPC_KIND_PROGRAM, 1'b1, 24'h000010, dat(0));
    sc(8'h06);
    frame(8'hD8, 24'h000000, 3, 0, 0, 0, 0);
    done(1'b0);
    lock = 1'b1;
    sc(8'h06);
    frame(8'h02, 24'h000010, 3, 1, 0, 0, 0);
    done(1'b0);
    lock = 1'b0;
    sc(8'hC1);
    `CHK({otp, regwr}, 2'h1)
  endtask
  task automatic t_program;
    bp = 4'h1;
    sc(8'h06);
    frame(8'h02, 24'hFF0010, 3, 1, 0, 0, 0);
    done(1'b0);
    frame(8'hD8, 24'hFF8000, 3, 0, 0, 0, 0);
    done(1'b0);
    bp = 4'h0;
    sc(8'h66);
    sc(8'h99);
    frame(8'h02, 24'h0001FE, 3, 4, 0, 0, 0);
    done(1'b0);
    sc(8'h06);
    frame(8'h02, 24'h0001FE, 3, 4, 0, 0, 0);
    done(1'b1);
    word(`SFEPC_KIND_PROGRAM, 1'b0, 24'h000100, dat(2));
    word(`SFEPC_KIND_PROGRAM, 1'b0, 24'h000101, dat(3));
    word(`SFEPC_KIND_PROGRAM, 1'b0, 24'h0001FE, dat(0));
    word(`SFEPC_KIND_PROGRAM, 1'b0, 24'h0001FF, dat(1));
  endtask
  task automatic t_quad;
    sc(8'h06);
    frame(8'h38, 24'h000200, 3, 1, 0, 0, 1);
    done(1'b0);
    qe = 1'b1;
    qpi = 1'b1;
    sc(8'h06);
    frame(8'h38, 24'h000200, 3, 1, 0, 1, 1);
    done(1'b0);
    qpi = 1'b0;
    sc(8'h06);
    frame(8'h38, 24'h000200, 3, 258, 0, 0, 1);
    done(1'b1);
    for (i = 0; i < 256; i = i + 1)
      word(`SFEPC_KIND_PROGRAM, 1'b0, {16'h0002, i[7:0]}, dat(i < 2 ? i + 256 : i));
    `CHK(words.size(), 0)
  endtask
  task automatic t_pd;
    frame(8'hB9, 24'h000000, 0, 0, 3, 0, 0);
    done(1'b0);
    sc(8'hB9);
    repeat (300) @(posedge clk_sys);
    #1 `CHK(dpd, 1'b0)
    repeat (120) @(posedge clk_sys);
    #1 `CHK(dpd, 1'b1)
    sc(8'h06);
    `CHK(write_enable_latch, 1'b0)
    frame(8'hD8, 24'h000000, 3, 0, 0, 0, 0);
    done(1'b0);
    sc(8'h66);
    sc(8'h99);
    `CHK(dpd, 1'b0)
    sc(8'hB9);
    repeat (420) @(posedge clk_sys);
    rst;
    t_reset;
  endtask
  task final_report;
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst;
    t_reset;
    t_erase;
    t_boundary;
    t_chip;
    t_otp;
    t_program;
    t_quad;
    t_pd;
    final_report;
  end
endmodule
